// ### logic/cdch_defs.vh
// Constants for the configuration completion and chain-enable handshake
`ifndef CDCH_DEFS_VH
`define CDCH_DEFS_VH

// Configuration scheme select
`define CDCH_SCHEME_ACTIVE_SERIAL   1'b0
`define CDCH_SCHEME_ACTIVE_PARALLEL 1'b1

// Handshake states
`define CDCH_ST_CONFIG 3'h0
`define CDCH_ST_WAIT   3'h1
`define CDCH_ST_INIT   3'h2
`define CDCH_ST_USER   3'h3
`define CDCH_ST_ERROR  3'h4
`define CDCH_ST_HOLD   3'h5

// Initialisation cycle length in clock cycles
`define CDCH_INIT_CYCLES 8'h20
`define CDCH_CNT_W       8

`endif

// ### logic/cdch_handshake.v
// Completion flag, chain enable and flash select handshake of the configuration loader
//
// Contract
// - Hold completion flag low during configuration.
// - Release flag when error-free data complete.
// - Initialise only after flag seen high.
// - Ignore flag low after user mode.
// - Accept configuration only while chain enable low.
// - Drive chain-enable output low when complete.
// - Flash select enables serial memory.
// - Flash select is parallel flash chip-enable.
// - Pull status line low on error.
// - Reconfig request low clears, high restarts.
`timescale 1ns/1ps
`default_nettype none
`include "cdch_defs.vh"

module cdch_handshake (
  input  wire       mclk_i,
  input  wire       rst_i,
  input  wire       clk_en_i,
  input  wire       reconfig_request_n_i,
  input  wire       chain_enable_n_i,
  input  wire       scheme_sel_i,
  input  wire       data_done_i,
  input  wire       data_error_i,
  input  wire       config_complete_flag_i,
  input  wire       status_n_i,
  output wire       config_complete_flag_o,
  output wire       config_complete_flag_oe_o,
  output wire       status_n_o,
  output wire       status_n_oe_o,
  output wire       chain_enable_n_o,
  output wire       chain_enable_n_oe_o,
  output reg        flash_select_n_o,
  output reg        load_enable_o,
  output reg        user_mode_o,
  output reg        config_error_o
);

  // ********************************************************************
  // State
  // ********************************************************************
  localparam [2:0] ST_CONFIG = `CDCH_ST_CONFIG;
  localparam [2:0] ST_WAIT   = `CDCH_ST_WAIT;
  localparam [2:0] ST_INIT   = `CDCH_ST_INIT;
  localparam [2:0] ST_USER   = `CDCH_ST_USER;
  localparam [2:0] ST_ERROR  = `CDCH_ST_ERROR;
  localparam [2:0] ST_HOLD   = `CDCH_ST_HOLD;

  reg  [2:0]              state;
  reg  [2:0]              next_state;
  reg  [`CDCH_CNT_W-1:0]  init_cnt;
  reg  [`CDCH_CNT_W-1:0]  next_init_cnt;
  reg                     flag_low;
  reg                     status_low;
  reg                     chain_low;
  reg                     next_flash_select_n;

  // ********************************************************************
  // Decode helpers
  // ********************************************************************
  // Loading state: data accepted and flash selected
  function st_loading;
    input [2:0] st;
    begin
      st_loading = (st == ST_CONFIG);
    end
  endfunction

  // Completion flag stays driven low until clean data is in
  function st_flag_driven;
    input [2:0] st;
    begin
      st_flag_driven = (st == ST_HOLD) || (st == ST_CONFIG) || (st == ST_ERROR);
    end
  endfunction

  // User mode, which also enables the next device in the chain
  function st_user;
    input [2:0] st;
    begin
      st_user = (st == ST_USER);
    end
  endfunction

  // Error state, latched until a reconfig request
  function st_error;
    input [2:0] st;
    begin
      st_error = (st == ST_ERROR);
    end
  endfunction

  // Counter step; the carry is dropped on purpose
  function [`CDCH_CNT_W-1:0] cnt_inc;
    input [`CDCH_CNT_W-1:0] cnt;
    reg   [`CDCH_CNT_W:0]   sum;
    begin
      sum     = {1'b0, cnt} + {{`CDCH_CNT_W{1'b0}}, 1'b1};
      cnt_inc = sum[`CDCH_CNT_W-1:0];
    end
  endfunction

  // Request low acts as a synchronous clear of the whole sequence
  wire restart = ~reconfig_request_n_i;

  // Last cycle of the initialisation count
  wire init_last = (init_cnt == `CDCH_INIT_CYCLES - 8'h01);

  // ********************************************************************
  // Next-state logic
  // ********************************************************************
  always @* begin
    next_state    = state;
    next_init_cnt = init_cnt;
    case (state)
      ST_HOLD: begin
        if (!chain_enable_n_i) begin
          next_state = ST_CONFIG;
        end
      end
      ST_CONFIG: begin
        if (chain_enable_n_i) begin
          next_state = ST_HOLD;
        end else if (data_error_i || !status_n_i) begin
          next_state = ST_ERROR;
        end else if (data_done_i) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!status_n_i) begin
          next_state = ST_ERROR;
        end else if (config_complete_flag_i) begin
          next_state    = ST_INIT;
          next_init_cnt = {`CDCH_CNT_W{1'b0}};
        end
      end
      ST_INIT: begin
        if (!status_n_i) begin
          next_state = ST_ERROR;
        end else if (init_last) begin
          next_state = ST_USER;
        end else begin
          next_init_cnt = cnt_inc(init_cnt);
        end
      end
      // User mode ignores flag and status pins until a reconfig request
      ST_USER: next_state = ST_USER;
      ST_ERROR: next_state = ST_ERROR;
      default: next_state = ST_HOLD;
    endcase
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state            <= ST_HOLD;
      init_cnt         <= {`CDCH_CNT_W{1'b0}};
      flag_low         <= 1'b1;
      status_low       <= 1'b0;
      chain_low        <= 1'b0;
      flash_select_n_o <= 1'b1;
      load_enable_o    <= 1'b0;
      user_mode_o      <= 1'b0;
      config_error_o   <= 1'b0;
    end else if (clk_en_i) begin
      if (restart) begin
        state            <= ST_HOLD;
        init_cnt         <= {`CDCH_CNT_W{1'b0}};
        flag_low         <= 1'b1;
        status_low       <= 1'b0;
        chain_low        <= 1'b0;
        flash_select_n_o <= 1'b1;
        load_enable_o    <= 1'b0;
        user_mode_o      <= 1'b0;
        config_error_o   <= 1'b0;
      end else begin
        state            <= next_state;
        init_cnt         <= next_init_cnt;
        flag_low         <= st_flag_driven(next_state);
        status_low       <= st_error(next_state);
        chain_low        <= st_user(next_state);
        flash_select_n_o <= next_flash_select_n;
        load_enable_o    <= st_loading(next_state);
        user_mode_o      <= st_user(next_state);
        config_error_o   <= st_error(next_state);
      end
    end
  end

  // ********************************************************************
  // Flash select
  // ********************************************************************
  // Both schemes share the active-low select; it enables the serial
  // memory or the parallel flash only while data is being read
  always @* begin
    if (scheme_sel_i == `CDCH_SCHEME_ACTIVE_SERIAL) begin
      next_flash_select_n = ~st_loading(next_state);
    end else begin
      next_flash_select_n = ~st_loading(next_state);
    end
  end

  // ********************************************************************
  // Open-drain pins
  // ********************************************************************
  assign config_complete_flag_o    = 1'b0;
  assign config_complete_flag_oe_o = flag_low;
  assign status_n_o                = 1'b0;
  assign status_n_oe_o             = status_low;
  assign chain_enable_n_o          = 1'b0;
  assign chain_enable_n_oe_o       = chain_low;

endmodule // cdch_handshake

`default_nettype wire

// ### sim/cdch_sva.sv
// Assertion checker for the completion flag and chain-enable handshake
`timescale 1ns/1ps
`default_nettype none
module cdch_sva (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic reconfig_request_n_i,
  input wire logic chain_enable_n_i,
  input wire logic data_error_i,
  input wire logic config_complete_flag_i,
  input wire logic status_n_i,
  input wire logic config_complete_flag_oe_o,
  input wire logic status_n_oe_o,
  input wire logic chain_enable_n_oe_o,
  input wire logic flash_select_n_o,
  input wire logic load_enable_o,
  input wire logic user_mode_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic run;
  logic loading;
  logic flag_seen;
  assign run     = clk_en_i && reconfig_request_n_i;
  assign loading = run && load_enable_o && !chain_enable_n_i;
  // Completion flag sensed high since loading last ran
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_seen <= 1'b0;
    end else if (!reconfig_request_n_i || load_enable_o) begin
      flag_seen <= 1'b0;
    end else if (config_complete_flag_i) begin
      flag_seen <= 1'b1;
    end
  end
  a_flag_held_low: assert property (load_enable_o |-> config_complete_flag_oe_o)
    else $error("flag released while loading");
  a_flag_freed: assert property ($rose(user_mode_o) |-> !config_complete_flag_oe_o)
    else $error("flag driven in user mode");
  a_init_after_flag: assert property ($rose(user_mode_o)
    |-> !$past(config_complete_flag_oe_o, 8)) else $error("user mode too soon after flag release");
  a_flag_seen_high: assert property ($rose(user_mode_o) |-> flag_seen)
    else $error("user mode without completion flag seen high");
  a_user_kept: assert property (user_mode_o && reconfig_request_n_i |=> user_mode_o)
    else $error("user mode lost");
  a_chain_gate: assert property (run && chain_enable_n_i |=> !load_enable_o)
    else $error("loading without chain enable");
  a_restart_clear: assert property (clk_en_i && !reconfig_request_n_i
    |=> config_complete_flag_oe_o && !user_mode_o) else $error("reconfig request did not clear");
  a_chain_out: assert property (chain_enable_n_oe_o == user_mode_o)
    else $error("chain output mismatch");
  a_flash_sel: assert property (load_enable_o |-> !flash_select_n_o)
    else $error("flash not selected while loading");
  a_flash_off: assert property (user_mode_o |-> flash_select_n_o)
    else $error("flash selected in user mode");
  a_err_pull: assert property (loading && data_error_i |=> status_n_oe_o)
    else $error("status not pulled on error");
  a_status_in: assert property (loading && !status_n_i |=> status_n_oe_o)
    else $error("status not pulled after outside status low");
  cover property ($rose(user_mode_o));
  cover property ($rose(status_n_oe_o));
  cover property ($rose(load_enable_o));
endmodule // cdch_sva
bind cdch_handshake cdch_sva u_cdch_sva (
  .mclk_i                    (mclk_i),
  .rst_i                     (rst_i),
  .clk_en_i                  (clk_en_i),
  .reconfig_request_n_i      (reconfig_request_n_i),
  .chain_enable_n_i          (chain_enable_n_i),
  .data_error_i              (data_error_i),
  .config_complete_flag_i    (config_complete_flag_i),
  .status_n_i                (status_n_i),
  .config_complete_flag_oe_o (config_complete_flag_oe_o),
  .status_n_oe_o             (status_n_oe_o),
  .chain_enable_n_oe_o       (chain_enable_n_oe_o),
  .flash_select_n_o          (flash_select_n_o),
  .load_enable_o             (load_enable_o),
  .user_mode_o               (user_mode_o)
);
`default_nettype wire

// ### sim/cdch_board.sv
// Board model: pull-ups on the flag and status pins and a host that may force either one low
`timescale 1ns/1ps
`default_nettype none
module cdch_board (
  input  wire logic flag_oe_i,
  input  wire logic ext_low_i,
  input  wire logic status_oe_i,
  input  wire logic ext_status_low_i,
  output logic      flag_o,
  output logic      status_o
);
  assign flag_o   = (flag_oe_i || ext_low_i) ? 1'b0 : 1'b1;
  assign status_o = (status_oe_i || ext_status_low_i) ? 1'b0 : 1'b1;
endmodule // cdch_board
`default_nettype wire

// ### sim/tb.sv
// Self-checking testbench for the completion flag and chain-enable handshake
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk_i = 0, rst_i = 1, rc_n = 1, sch = 0, done = 0, err = 0, ext = 0, sts = 0;
  logic ce_n = 0;
  logic f_oe, s_oe, c_oe, fs_n, ld, um, er, f_pin, s_pin, od_f, od_s, od_c;
  int   mismatches = 0, samples_checked = 0;
  cdch_handshake u_cdch_handshake (.mclk_i, .rst_i, .clk_en_i(1'b1), .reconfig_request_n_i(rc_n),
    .chain_enable_n_i(ce_n), .scheme_sel_i(sch), .data_done_i(done), .data_error_i(err),
    .config_complete_flag_i(f_pin), .status_n_i(s_pin), .config_complete_flag_o(od_f),
    .config_complete_flag_oe_o(f_oe), .status_n_o(od_s), .status_n_oe_o(s_oe),
    .chain_enable_n_o(od_c), .chain_enable_n_oe_o(c_oe), .flash_select_n_o(fs_n),
    .load_enable_o(ld), .user_mode_o(um), .config_error_o(er));
  // Single device: the chain output feeds no further device on this board
  cdch_board u_cdch_board (.flag_oe_i(f_oe), .ext_low_i(ext), .status_oe_i(s_oe),
    .ext_status_low_i(sts), .flag_o(f_pin), .status_o(s_pin));
  initial forever #5 mclk_i = ~mclk_i;
  task chk(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task restart;
    rc_n = 0;
    cyc(1);
    rc_n = 1;
    cyc(2);
  endtask
  task t_reset;
    rst_i = 1;
    cyc(1);
    chk(f_oe, 1);
    chk(od_f, 0);
    chk(s_oe, 0);
    chk(od_s, 0);
    chk(c_oe, 0);
    chk(od_c, 0);
    chk(fs_n, 1);
    chk(ld, 0);
    chk(um, 0);
    chk(er, 0);
    rst_i = 0;
    cyc(1);
    chk(ld, 1);
    chk(f_oe, 1);
  endtask
  task t_boot(input logic s);
    sch = s;
    restart;
    chk(ld, 1);
    chk(fs_n, 0);
    chk(f_oe, 1);
    ext = 1;
    done = 1;
    cyc(1);
    done = 0;
    cyc(1);
    chk(f_oe, 0);
    chk(fs_n, 1);
    cyc(4);
    chk(um, 0);
    ext = 0;
    // Flag seen high at the next edge, then 32 init cycles
    cyc(32);
    chk(um, 0);
    cyc(1);
    chk(um, 1);
    chk(c_oe, 1);
    ext = 1;
    sts = 1;
    cyc(3);
    chk(um, 1);
    chk(c_oe, 1);
    chk(s_oe, 0);
    ext = 0;
    sts = 0;
  endtask
  task t_err;
    rc_n = 0;
    cyc(1);
    chk(um, 0);
    chk(f_oe, 1);
    restart;
    err = 1;
    cyc(1);
    err = 0;
    cyc(1);
    chk(s_oe, 1);
    chk(er, 1);
    chk(f_oe, 1);
    restart;
    chk(s_oe, 0);
    chk(er, 0);
    sts = 1;
    cyc(1);
    sts = 0;
    cyc(1);
    chk(er, 1);
    chk(ld, 0);
    restart;
  endtask
  task t_chain;
    ce_n = 1;
    restart;
    chk(ld, 0);
    chk(f_oe, 1);
    ce_n = 0;
    cyc(1);
    chk(ld, 1);
    ce_n = 1;
    cyc(1);
    chk(ld, 0);
    chk(fs_n, 1);
    ce_n = 0;
  endtask
  task test_done;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    cyc(4);
    t_reset;
    t_boot(1'b0);
    t_reset;
    t_boot(1'b1);
    t_err;
    t_chain;
    test_done;
  end
  initial begin
    #20000;
    mismatches++;
    test_done;
  end
endmodule // tb
`default_nettype wire
